/* ipmc_pkg.sv */
package ipmc_pkg;
  // Register addresses on the plain register port.
  localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h87;
  localparam logic [7:0] ADDR_SECOND_ENABLE   = 8'ha7;
  localparam logic [7:0] ADDR_FIRST_ENABLE    = 8'ha8;
  localparam logic [7:0] ADDR_SECOND_PRIORITY = 8'hb7;
  localparam logic [7:0] ADDR_FIRST_PRIORITY  = 8'hb8;
  localparam logic [7:0] ADDR_SERVICE_STATUS  = 8'hc0;
  // Reset values.
  localparam logic [7:0] RST_POWER_CONTROL    = 8'h00;
  localparam logic [7:0] RST_ENABLE           = 8'h00;
  localparam logic [7:0] RST_PRIORITY         = 8'h00;
  // Power control fields.
  localparam int PCTL_IDLE_BIT     = 0;
  localparam int PCTL_PDOWN_BIT    = 1;
  localparam int PCTL_ADC_IRQ_BIT  = 4;
  localparam int PCTL_LVR_DIS_BIT  = 5;
  // First enable/priority fields.
  localparam int FE_GLOBAL_BIT     = 7;
  localparam int F_EXT0_BIT        = 0;
  localparam int F_TMR0_BIT        = 1;
  localparam int F_EXT1_BIT        = 2;
  localparam int F_TMR1_BIT        = 3;
  localparam int F_SER1_BIT        = 4;
  localparam int F_TMR2_BIT        = 5;
  // Second enable/priority fields.
  localparam int S_USB_BIT         = 0;
  localparam int S_TWI_BIT         = 1;
  localparam int S_SER2_BIT        = 4;
  localparam int S_DISP_BIT        = 7;
  localparam logic [7:0] SECOND_USED_MASK = 8'h93;
  localparam logic [7:0] FIRST_PRIO_MASK  = 8'h3f;
  // Sources in polling order, index 0 polled first.
  localparam int NUM_SRC = 10;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_SER2 = 16'h004b;
  localparam logic [15:0] VEC_TMR0 = 16'h000b;
  localparam logic [15:0] VEC_TWI  = 16'h0043;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_DISP = 16'h003b;
  localparam logic [15:0] VEC_TMR1 = 16'h001b;
  localparam logic [15:0] VEC_USB  = 16'h0033;
  localparam logic [15:0] VEC_SER1 = 16'h0023;
  localparam logic [15:0] VEC_TMR2 = 16'h002b;
  // Restart delay after an internal reset ends idle, in machine cycles.
  localparam logic [1:0] RESTART_CYCLES = 2'h3;
  typedef enum logic [1:0]
  {
    PM_RUN     = 2'b00,
    PM_IDLE    = 2'b01,
    PM_PDOWN   = 2'b10,
    PM_RESTART = 2'b11
  } ipmc_mode_type;
endpackage : ipmc_pkg

/* ipmc_arbiter.sv */
// Picks the first source in polling order from a request vector.
module ipmc_arbiter #(
  parameter int N = 10
) (
  // Requests
  input  wire logic [N-1:0] req_i,
  // Result
  output logic              any_o,
  output logic [3:0]        idx_o
);
  always_comb
  begin
    any_o = 1'b0;
    idx_o = 4'h0;
    for (int k = N - 1; k >= 0; k--)
    begin
      if (req_i[k])
      begin
        any_o = 1'b1;
        idx_o = 4'(k);
      end
    end
  end
endmodule : ipmc_arbiter

/* ipmc_service.sv */
// In-service level tracking: one bit for low, one for high.
module ipmc_service (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Events
  input  wire logic take_i,
  input  wire logic take_high_i,
  input  wire logic return_from_interrupt_i,
  // State
  output logic      low_busy_o,
  output logic      high_busy_o
);
  logic low_ff;
  logic high_ff;
  logic nxt_low;
  logic nxt_high;
  // The return-from-interrupt clears the highest level active; a plain return does nothing.
  assign nxt_high = take_i && take_high_i ? 1'b1 : (return_from_interrupt_i ? 1'b0 : high_ff);
  assign nxt_low  = take_i && !take_high_i ? 1'b1 : ((return_from_interrupt_i && !high_ff) ? 1'b0 : low_ff);
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      low_ff  <= 1'b0;
      high_ff <= 1'b0;
    end
    else
    begin
      low_ff  <= nxt_low;
      high_ff <= nxt_high;
    end
  end
  assign low_busy_o  = low_ff;
  assign high_busy_o = high_ff;
endmodule : ipmc_service

/* ipmc_top.sv */
// Implementation choice: the address-and-strobe port.
module ipmc_top (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  // Interrupt request flags, polling order: ext0 ser2 tmr0 twi ext1 disp tmr1 usb ser1 tmr2
  input  wire logic [9:0]  irq_flags_i,
  // CPU sequencer
  input  wire logic        last_cycle_i,
  input  wire logic        return_from_interrupt_exec_i,
  input  wire logic        ret_exec_i,
  input  wire logic        int_reg_access_i,
  input  wire logic [15:0] pc_i,
  input  wire logic        internal_reset_i,
  output logic             call_o,
  output logic [15:0]      call_vector_o,
  output logic [15:0]      push_pc_o,
  output logic             save_status_o,
  // Power
  output logic             cpu_halt_o,
  output logic             clock_stop_o,
  output logic             periph_gate_o,
  output logic             lvr_disable_o,
  output logic             adc_irq_enable_o
);
  logic [7:0]  pctl_ff;
  logic [7:0]  fen_ff;
  logic [7:0]  sen_ff;
  logic [7:0]  fpr_ff;
  logic [7:0]  spr_ff;
  logic [9:0]  samp_ff;
  logic        block_ff;
  logic [7:0]  rdata_ff;
  logic        call_ff;
  logic [15:0] vec_ff;
  logic [15:0] push_ff;
  logic [1:0]  rcnt_ff;
  ipmc_pkg::ipmc_mode_type mode_ff;
  ipmc_pkg::ipmc_mode_type nxt_mode;
  logic [9:0]  src_en;
  logic [9:0]  src_hi;
  logic [9:0]  req_hi;
  logic [9:0]  req_lo;
  logic        any_hi;
  logic        any_lo;
  logic [3:0]  idx_hi;
  logic [3:0]  idx_lo;
  logic        low_busy;
  logic        high_busy;
  logic        allow_hi;
  logic        allow_lo;
  logic        take;
  logic        take_high;
  logic [3:0]  take_idx;
  logic [15:0] take_vec;
  logic        wake;
  logic        wr_pctl;
  logic        wr_fen;
  logic        wr_sen;
  logic        wr_fpr;
  logic        wr_spr;
  logic [7:0]  rd_mux;
  logic [7:0]  nxt_pctl;
  logic        pctl_idle_set;
  logic        pctl_pdown_set;
  logic [15:0] vec_table [10];
  logic        halt_ff;
  logic        stop_ff;

  assign vec_table[0] = ipmc_pkg::VEC_EXT0;
  assign vec_table[1] = ipmc_pkg::VEC_SER2;
  assign vec_table[2] = ipmc_pkg::VEC_TMR0;
  assign vec_table[3] = ipmc_pkg::VEC_TWI;
  assign vec_table[4] = ipmc_pkg::VEC_EXT1;
  assign vec_table[5] = ipmc_pkg::VEC_DISP;
  assign vec_table[6] = ipmc_pkg::VEC_TMR1;
  assign vec_table[7] = ipmc_pkg::VEC_USB;
  assign vec_table[8] = ipmc_pkg::VEC_SER1;
  assign vec_table[9] = ipmc_pkg::VEC_TMR2;

  // Enables and priorities mapped into polling order.
  assign src_en = {fen_ff[ipmc_pkg::F_TMR2_BIT], fen_ff[ipmc_pkg::F_SER1_BIT], sen_ff[ipmc_pkg::S_USB_BIT],
                   fen_ff[ipmc_pkg::F_TMR1_BIT], sen_ff[ipmc_pkg::S_DISP_BIT], fen_ff[ipmc_pkg::F_EXT1_BIT],
                   sen_ff[ipmc_pkg::S_TWI_BIT], fen_ff[ipmc_pkg::F_TMR0_BIT], sen_ff[ipmc_pkg::S_SER2_BIT],
                   fen_ff[ipmc_pkg::F_EXT0_BIT]};
  assign src_hi = {fpr_ff[ipmc_pkg::F_TMR2_BIT], fpr_ff[ipmc_pkg::F_SER1_BIT], spr_ff[ipmc_pkg::S_USB_BIT],
                   fpr_ff[ipmc_pkg::F_TMR1_BIT], spr_ff[ipmc_pkg::S_DISP_BIT], fpr_ff[ipmc_pkg::F_EXT1_BIT],
                   spr_ff[ipmc_pkg::S_TWI_BIT], fpr_ff[ipmc_pkg::F_TMR0_BIT], spr_ff[ipmc_pkg::S_SER2_BIT],
                   fpr_ff[ipmc_pkg::F_EXT0_BIT]};
  // Only the samples from the previous cycle are polled, so nothing is remembered.
  assign req_hi = samp_ff & src_en & src_hi & {10{fen_ff[ipmc_pkg::FE_GLOBAL_BIT]}};
  assign req_lo = samp_ff & src_en & ~src_hi & {10{fen_ff[ipmc_pkg::FE_GLOBAL_BIT]}};

  ipmc_arbiter #(.N(ipmc_pkg::NUM_SRC)) u_arb_hi (
    .req_i (req_hi),
    .any_o (any_hi),
    .idx_o (idx_hi)
  );
  ipmc_arbiter #(.N(ipmc_pkg::NUM_SRC)) u_arb_lo (
    .req_i (req_lo),
    .any_o (any_lo),
    .idx_o (idx_lo)
  );

  // A high handler is never preempted; a low handler only by a high request.
  assign allow_hi  = any_hi && !high_busy;
  assign allow_lo  = any_lo && !high_busy && !low_busy;
  assign wake      = allow_hi || allow_lo;
  // Idle ends on a request; the call waits for the first live boundary.
  assign take      = wake && last_cycle_i && !block_ff && !int_reg_access_i && !return_from_interrupt_exec_i
                     && mode_ff == ipmc_pkg::PM_RUN && !call_ff;
  assign take_high = allow_hi;
  assign take_idx  = allow_hi ? idx_hi : idx_lo;
  assign take_vec  = vec_table[take_idx];

  ipmc_service u_service (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .take_i      (take),
    .take_high_i (take_high),
    .return_from_interrupt_i      (return_from_interrupt_exec_i && last_cycle_i),
    .low_busy_o  (low_busy),
    .high_busy_o (high_busy)
  );

  // Register decode.
  assign wr_pctl = reg_wr_i && reg_addr_i == ipmc_pkg::ADDR_POWER_CONTROL;
  assign wr_fen  = reg_wr_i && reg_addr_i == ipmc_pkg::ADDR_FIRST_ENABLE;
  assign wr_sen  = reg_wr_i && reg_addr_i == ipmc_pkg::ADDR_SECOND_ENABLE;
  assign wr_fpr  = reg_wr_i && reg_addr_i == ipmc_pkg::ADDR_FIRST_PRIORITY;
  assign wr_spr  = reg_wr_i && reg_addr_i == ipmc_pkg::ADDR_SECOND_PRIORITY;
  assign rd_mux  = (reg_addr_i == ipmc_pkg::ADDR_POWER_CONTROL)   ? pctl_ff :
                   (reg_addr_i == ipmc_pkg::ADDR_FIRST_ENABLE)    ? fen_ff :
                   (reg_addr_i == ipmc_pkg::ADDR_SECOND_ENABLE)   ? sen_ff :
                   (reg_addr_i == ipmc_pkg::ADDR_FIRST_PRIORITY)  ? fpr_ff :
                   (reg_addr_i == ipmc_pkg::ADDR_SECOND_PRIORITY) ? spr_ff :
                   (reg_addr_i == ipmc_pkg::ADDR_SERVICE_STATUS)  ? {4'h0, mode_ff, high_busy, low_busy} :
                   8'h00;

  // The wake-up clears the idle bit in hardware; a write in that cycle loses to it.
  assign nxt_pctl = wr_pctl ? reg_wdata_i : pctl_ff;
  assign pctl_idle_set  = wr_pctl && reg_wdata_i[ipmc_pkg::PCTL_IDLE_BIT];
  assign pctl_pdown_set = wr_pctl && reg_wdata_i[ipmc_pkg::PCTL_PDOWN_BIT];

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      pctl_ff <= ipmc_pkg::RST_POWER_CONTROL;
      fen_ff  <= ipmc_pkg::RST_ENABLE;
      sen_ff  <= ipmc_pkg::RST_ENABLE;
      fpr_ff  <= ipmc_pkg::RST_PRIORITY;
      spr_ff  <= ipmc_pkg::RST_PRIORITY;
    end
    else
    begin
      pctl_ff <= nxt_pctl;
      if (mode_ff == ipmc_pkg::PM_IDLE && wake)
        pctl_ff[ipmc_pkg::PCTL_IDLE_BIT] <= 1'b0;
      if (wr_fen)
        fen_ff <= reg_wdata_i;
      if (wr_sen)
        sen_ff <= reg_wdata_i & ipmc_pkg::SECOND_USED_MASK;
      if (wr_fpr)
        fpr_ff <= reg_wdata_i & ipmc_pkg::FIRST_PRIO_MASK;
      if (wr_spr)
        spr_ff <= reg_wdata_i & ipmc_pkg::SECOND_USED_MASK;
    end
  end

  // Flags are captured once per machine cycle, also during idle.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      samp_ff  <= 10'h000;
      block_ff <= 1'b0;
    end
    else
    begin
      samp_ff  <= irq_flags_i;
      if (last_cycle_i)
        block_ff <= return_from_interrupt_exec_i || int_reg_access_i;
    end
  end

  // Power mode sequencing.
  always_comb
  begin
    nxt_mode = mode_ff;
    case (mode_ff)
      ipmc_pkg::PM_RUN:
      begin
        if (pctl_pdown_set)
          nxt_mode = ipmc_pkg::PM_PDOWN;
        else if (pctl_idle_set)
          nxt_mode = ipmc_pkg::PM_IDLE;
      end
      ipmc_pkg::PM_IDLE:
      begin
        if (internal_reset_i)
          nxt_mode = ipmc_pkg::PM_RESTART;
        else if (wake)
          nxt_mode = ipmc_pkg::PM_RUN;
      end
      ipmc_pkg::PM_PDOWN:
        nxt_mode = ipmc_pkg::PM_PDOWN;
      ipmc_pkg::PM_RESTART:
      begin
        if (rcnt_ff == ipmc_pkg::RESTART_CYCLES - 2'h1)
          nxt_mode = ipmc_pkg::PM_RUN;
      end
      default:
        nxt_mode = ipmc_pkg::PM_RUN;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      mode_ff <= ipmc_pkg::PM_RUN;
      rcnt_ff <= 2'h0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      rcnt_ff <= (mode_ff == ipmc_pkg::PM_RESTART) ? rcnt_ff + 2'h1 : 2'h0;
    end
  end

  // Power outputs follow the next mode so that they change together with it.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      halt_ff <= 1'b0;
      stop_ff <= 1'b0;
    end
    else
    begin
      halt_ff <= nxt_mode != ipmc_pkg::PM_RUN;
      stop_ff <= nxt_mode == ipmc_pkg::PM_PDOWN;
    end
  end

  // Call outputs and read data.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      call_ff  <= 1'b0;
      vec_ff   <= 16'h0000;
      push_ff  <= 16'h0000;
      rdata_ff <= 8'h00;
    end
    else
    begin
      call_ff  <= take;
      if (take)
      begin
        vec_ff  <= take_vec;
        push_ff <= pc_i;
      end
      if (reg_rd_i)
        rdata_ff <= rd_mux;
    end
  end

  assign reg_rdata_o      = rdata_ff;
  assign call_o           = call_ff;
  assign call_vector_o    = vec_ff;
  assign push_pc_o        = push_ff;
  assign save_status_o    = 1'b0;
  assign cpu_halt_o       = halt_ff;
  assign clock_stop_o     = stop_ff;
  assign periph_gate_o    = stop_ff;
  assign lvr_disable_o    = pctl_ff[ipmc_pkg::PCTL_LVR_DIS_BIT];
  assign adc_irq_enable_o = pctl_ff[ipmc_pkg::PCTL_ADC_IRQ_BIT];

  // Checks.
  call_boundary_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    call_o |-> $past(last_cycle_i)) else $error("call launched off a boundary");
  call_block_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    call_o |-> !$past(return_from_interrupt_exec_i) && !$past(int_reg_access_i)) else $error("call during blocked instruction");
  high_nest_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    high_busy && take |-> 1'b0) else $error("high handler preempted");
  pdown_sticky_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_ff == ipmc_pkg::PM_PDOWN |=> mode_ff == ipmc_pkg::PM_PDOWN) else $error("power-down left without reset");
  restart_delay_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_ff == ipmc_pkg::PM_IDLE && internal_reset_i |=> mode_ff == ipmc_pkg::PM_RESTART [*3] ##1
    mode_ff == ipmc_pkg::PM_RUN) else $error("restart delay wrong");
  vec_ext0_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    take && take_idx == 4'h0 |=> call_vector_o == 16'h0003) else $error("ext0 vector wrong");
  idle_wake_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_ff == ipmc_pkg::PM_IDLE && wake && !internal_reset_i |=> !pctl_ff[0] && !cpu_halt_o)
    else $error("idle not ended by interrupt");
  global_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !fen_ff[7] |=> !call_o) else $error("call with global enable off");
  pctl_reset_a: assert property (@(posedge clock_i)
    !rst_n_i |=> pctl_ff == 8'h00) else $error("power control reset wrong");
  return_from_interrupt_block_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    return_from_interrupt_exec_i && last_cycle_i |=> !call_o ##1 !call_o) else $error("call right after interrupt return");
  plain_ret_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ret_exec_i && !return_from_interrupt_exec_i && !take |=> $stable(low_busy) && $stable(high_busy))
    else $error("plain return changed service state");
  pdown_entry_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_ff == ipmc_pkg::PM_RUN && pctl_pdown_set |=> clock_stop_o && periph_gate_o && cpu_halt_o)
    else $error("power-down not entered");
  idle_entry_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_ff == ipmc_pkg::PM_RUN && pctl_idle_set && !pctl_pdown_set |=> cpu_halt_o && !clock_stop_o)
    else $error("idle not entered");
  cov_call: cover property (@(posedge clock_i) disable iff (!rst_n_i) call_o);
  cov_nest: cover property (@(posedge clock_i) disable iff (!rst_n_i) low_busy && take && take_high);
  cov_idle_wake: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_ff == ipmc_pkg::PM_IDLE ##1 mode_ff == ipmc_pkg::PM_RUN);
  cov_restart: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_ff == ipmc_pkg::PM_RESTART ##1 mode_ff == ipmc_pkg::PM_RUN);
  cov_pdown: cover property (@(posedge clock_i) disable iff (!rst_n_i) clock_stop_o);
endmodule : ipmc_top

/* ipmc_cpu_model.sv */
// Behavioural instruction sequencer that faces the controller.
module ipmc_cpu_model (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Bench control
  input  wire logic        slow_i,
  input  wire logic [1:0]  kind_i,
  // From the controller
  input  wire logic        halt_i,
  input  wire logic        call_i,
  input  wire logic [15:0] vector_i,
  // To the controller
  output logic             last_cycle_o,
  output logic             return_from_interrupt_o,
  output logic             ret_o,
  output logic             access_o,
  output logic [15:0]      pc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        phase_ff;
  logic [15:0] pc_ff;
  // A halted CPU never reaches an instruction boundary; slow mode runs two-cycle instructions.
  assign last_cycle_o = !halt_i && (!slow_i || phase_ff);
  assign return_from_interrupt_o       = kind_i == 2'h1;
  assign ret_o        = kind_i == 2'h2;
  assign access_o     = kind_i == 2'h3;
  assign pc_o         = pc_ff;
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      phase_ff <= 1'b0;
      pc_ff    <= 16'h0100;
    end
    else
    begin
      phase_ff <= halt_i ? phase_ff : !phase_ff;
      if (call_i)
        pc_ff <= vector_i;
      else if (last_cycle_o)
        pc_ff <= pc_ff + 16'h0001;
    end
  end
endmodule : ipmc_cpu_model

/* testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock     = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [9:0]  flags     = 10'h000;
  logic        slow      = 1'b0;
  logic [1:0]  kind      = 2'h0;
  logic        int_reset = 1'b0;
  logic [7:0]  reg_rdata;
  logic [7:0]  rdv;
  logic [15:0] pc, vector, push_pc;
  logic        last_cycle, return_from_interrupt, ret, access, call, save_status;
  logic        halt, clock_stop, periph_gate, lvr_dis, adc_en;
  int          err_total       = 0;
  int          samples_checked = 0;
  localparam logic [15:0] VECS [10] = '{ipmc_pkg::VEC_EXT0, ipmc_pkg::VEC_SER2, ipmc_pkg::VEC_TMR0,
    ipmc_pkg::VEC_TWI, ipmc_pkg::VEC_EXT1, ipmc_pkg::VEC_DISP, ipmc_pkg::VEC_TMR1, ipmc_pkg::VEC_USB,
    ipmc_pkg::VEC_SER1, ipmc_pkg::VEC_TMR2};

  always #50 clock = ~clock;

  ipmc_top i_ipmc_top (.clock_i(clock), .rst_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_flags_i(flags),
    .last_cycle_i(last_cycle), .return_from_interrupt_exec_i(return_from_interrupt), .ret_exec_i(ret), .int_reg_access_i(access), .pc_i(pc),
    .internal_reset_i(int_reset), .call_o(call), .call_vector_o(vector), .push_pc_o(push_pc),
    .save_status_o(save_status), .cpu_halt_o(halt), .clock_stop_o(clock_stop), .periph_gate_o(periph_gate),
    .lvr_disable_o(lvr_dis), .adc_irq_enable_o(adc_en));

  ipmc_cpu_model i_ipmc_cpu_model (.clock_i(clock), .rst_n_i(rst_n), .slow_i(slow), .kind_i(kind),
    .halt_i(halt), .call_i(call), .vector_i(vector), .last_cycle_o(last_cycle), .return_from_interrupt_o(return_from_interrupt),
    .ret_o(ret), .access_o(access), .pc_o(pc));

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask : rd

  // One single-cycle instruction of the given kind: 1 return from interrupt, 2 plain return, 3 access.
  task automatic instr(input logic [1:0] k);
    @(posedge clock);
    kind <= k;
    @(posedge clock);
    kind <= 2'h0;
  endtask : instr

  task automatic set_flags(input logic [9:0] f);
    @(posedge clock);
    flags <= f;
  endtask : set_flags

  task automatic wait_call(input logic [15:0] exp);
    int          n;
    logic [15:0] ret_pc;
    logic        lc;
    n = 0;
    #1;
    ret_pc = pc;
    lc     = last_cycle;
    do
    begin
      @(posedge clock);
      #1;
      n++;
      if (call !== 1'b1)
      begin
        ret_pc = pc;
        lc     = last_cycle;
      end
    end
    while (call !== 1'b1 && n < 12);
    check(16'(call), 16'h0001);
    check(vector, exp);
    check(push_pc, ret_pc);
    check(16'(lc), 16'h0001);
    check(16'(save_status), 16'h0000);
  endtask : wait_call

  task automatic no_call(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clock);
      #1;
      if (call !== 1'b0)
        seen = 1'b1;
    end
    check(16'(seen), 16'h0000);
  endtask : no_call

  task automatic t_regs();
    rd(ipmc_pkg::ADDR_POWER_CONTROL);
    check(16'(rdv), 16'h0000);
    wr(ipmc_pkg::ADDR_SECOND_PRIORITY, 8'hff);
    rd(ipmc_pkg::ADDR_SECOND_PRIORITY);
    check(16'(rdv), 16'h0093);
    wr(ipmc_pkg::ADDR_SECOND_PRIORITY, 8'h00);
    rd(8'h55);
    check(16'(rdv), 16'h0000);
    wr(ipmc_pkg::ADDR_POWER_CONTROL, 8'h30);
    @(posedge clock);
    #1;
    check(16'({lvr_dis, adc_en}), 16'h0003);
    wr(ipmc_pkg::ADDR_POWER_CONTROL, 8'h00);
  endtask : t_regs

  // All sources at once: served one by one in polling order, each through its own vector.
  task automatic t_order();
    wr(ipmc_pkg::ADDR_FIRST_ENABLE, 8'hbf);
    wr(ipmc_pkg::ADDR_SECOND_ENABLE, 8'h93);
    set_flags(10'h3ff);
    for (int i = 0; i < 10; i++)
    begin
      wait_call(VECS[i]);
      @(posedge clock);
      flags[i] <= 1'b0;
      instr(2'h1);
    end
    no_call(6);
  endtask : t_order

  task automatic t_prio();
    wr(ipmc_pkg::ADDR_FIRST_PRIORITY, 8'h20);
    set_flags(10'h001);
    wait_call(ipmc_pkg::VEC_EXT0);
    set_flags(10'h000);
    instr(2'h2);
    rd(ipmc_pkg::ADDR_SERVICE_STATUS);
    check(16'(rdv), 16'h0001);
    set_flags(10'h010);
    no_call(6);
    set_flags(10'h210);
    wait_call(ipmc_pkg::VEC_TMR2);
    set_flags(10'h010);
    no_call(6);
    instr(2'h1);
    no_call(6);
    instr(2'h1);
    wait_call(ipmc_pkg::VEC_EXT1);
    set_flags(10'h000);
    instr(2'h1);
    wr(ipmc_pkg::ADDR_FIRST_PRIORITY, 8'h00);
  endtask : t_prio

  task automatic t_block();
    @(posedge clock);
    kind  <= 2'h3;
    flags <= 10'h004;
    no_call(8);
    set_flags(10'h000);
    repeat (2) @(posedge clock);
    kind <= 2'h0;
    no_call(8);
    @(posedge clock);
    slow  <= 1'b1;
    flags <= 10'h004;
    wait_call(ipmc_pkg::VEC_TMR0);
    @(posedge clock);
    slow  <= 1'b0;
    flags <= 10'h000;
    instr(2'h1);
    wr(ipmc_pkg::ADDR_FIRST_ENABLE, 8'h3f);
    set_flags(10'h001);
    no_call(6);
    wr(ipmc_pkg::ADDR_FIRST_ENABLE, 8'hbe);
    no_call(6);
    wr(ipmc_pkg::ADDR_FIRST_ENABLE, 8'hbf);
    wait_call(ipmc_pkg::VEC_EXT0);
    set_flags(10'h000);
    instr(2'h1);
  endtask : t_block

  task automatic t_idle();
    wr(ipmc_pkg::ADDR_FIRST_ENABLE, 8'hbe);
    wr(ipmc_pkg::ADDR_POWER_CONTROL, 8'h01);
    set_flags(10'h001);
    no_call(6);
    check(16'(halt), 16'h0001);
    rd(ipmc_pkg::ADDR_SERVICE_STATUS);
    check(16'(rdv), 16'h0004);
    wr(ipmc_pkg::ADDR_FIRST_ENABLE, 8'hbf);
    wait_call(ipmc_pkg::VEC_EXT0);
    check(16'(halt), 16'h0000);
    set_flags(10'h000);
    rd(ipmc_pkg::ADDR_POWER_CONTROL);
    check(16'(rdv), 16'h0000);
    instr(2'h1);
  endtask : t_idle

  task automatic t_ireset();
    int n;
    wr(ipmc_pkg::ADDR_POWER_CONTROL, 8'h01);
    repeat (2) @(posedge clock);
    int_reset <= 1'b1;
    @(posedge clock);
    int_reset <= 1'b0;
    #1;
    n = 0;
    while (halt === 1'b1 && n < 10)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check(16'(n), 16'h0003);
  endtask : t_ireset

  task automatic t_pdown();
    wr(ipmc_pkg::ADDR_POWER_CONTROL, 8'h02);
    @(posedge clock);
    #1;
    check(16'({clock_stop, periph_gate, halt}), 16'h0007);
    set_flags(10'h001);
    no_call(6);
    check(16'(clock_stop), 16'h0001);
    @(posedge clock);
    rst_n <= 1'b0;
    flags <= 10'h000;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    check(16'(clock_stop), 16'h0000);
  endtask : t_pdown

  initial
  begin
    #500000;
    err_total++;
    give_verdict();
  end

  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_order();
    t_prio();
    t_block();
    t_idle();
    t_ireset();
    t_pdown();
    give_verdict();
  end
endmodule : testbench
